/* rrp_pkg.sv */
package rrp_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_SYNTH_MAIN = 6'h16;
    localparam logic [5:0] ADDR_SYNTH_AUX  = 6'h17;
    localparam logic [5:0] ADDR_DAC        = 6'h18;
    localparam logic [5:0] ADDR_ADC        = 6'h19;
    localparam logic [5:0] ADDR_RXLEN_HI   = 6'h1a;
    localparam logic [5:0] ADDR_RXLEN_LO   = 6'h1b;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [23:0] RST_SYNTH_MAIN = 24'h40d84f;
    localparam logic [23:0] RST_SYNTH_AUX  = 24'h011846;
    localparam logic [7:0]  RST_DAC        = 8'h00;
    localparam logic [7:0]  RST_RXLEN      = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_BIAS_BOOST   = 23;
    localparam int REF_SEL_HI       = 22;
    localparam int REF_SEL_LO       = 20;
    localparam int BIT_VCO_LEVEL    = 22;
    localparam int BIT_EXT_RF       = 21;
    localparam int BIT_PRESC_EN     = 20;
    localparam int B_HI             = 19;
    localparam int B_LO             = 10;
    localparam int A_HI             = 9;
    localparam int A_LO             = 0;
    localparam int BIT_SKIP_CHECK   = 7;
    localparam int BIT_IRQ_REMAP    = 6;

    // ----------------------------------------------------------------
    // commands
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SOFT_INIT  = 8'h83;
    localparam logic [7:0] CMD_HOP_MAIN   = 8'h84;
    localparam logic [7:0] CMD_HOP_AUX    = 8'h85;
    localparam logic [7:0] CMD_ADC_TRIG   = 8'h87;
    localparam logic [7:0] CMD_INV_FIRST  = 8'h98;
    localparam logic [7:0] CMD_INV_LAST   = 8'h9c;
    localparam logic [7:0] CMD_REQ_RN     = 8'h9f;
    localparam logic [9:0] RXLEN_TAG_RANDOM_16     = 10'd16;
    localparam logic [9:0] RXLEN_TAG_RANDOM_16_CRC = 10'd32;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int ADC_TIME_US    = 20;
    localparam int ADC_CYCLES     = (ADC_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       bias_boost;
        logic [2:0] reference_divider_select;
        logic [9:0] b_count;
        logic [9:0] a_count;
    } rrp_synth_type;

    typedef struct packed {
        logic       single_rx_skip_check;
        logic       raw_fifo_irq_remap;
        logic [9:0] bit_count;
        logic       stop_on_pause;
    } rrp_rx_cfg_type;

    typedef enum logic [2:0] {
        ADC_IDLE = 3'b001,
        ADC_BUSY = 3'b010,
        ADC_DONE = 3'b100
    } rrp_adc_state_type;

endpackage

/* rrp_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// [RQ1] main word bits 22:20 select the synthesizer reference frequency
// [RQ2] both words: bits 19:10 are B count, bits 9:0 are A count
// [RQ3] main word presets to 40d84f on reset or enable low
// [RQ4] aux word presets to 011846 on reset or enable low
// [RQ5] aux bit 21 picks internal oscillator or external rf pin
// [RQ6] aux bit 20 enables divider and prescaler path
// [RQ7] dac level is host writable, resets to 00
// [RQ8] command 87 starts conversion; result valid 20 us later
// [RQ9] host sets measurement select before triggering conversion
// [RQ10] length bit 7 skips crc check for next reception only
// [RQ11] length bit 6 sends all bytes to fifo and remaps interrupts
// [RQ12] ten-bit length: two high bits in first, eight in second register
// [RQ13] nonzero length stops after count; zero stops on closing pause
// [RQ14] commands 98 to 9c force a 16-bit reception length
// [RQ15] command 9f forces a 32-bit reception length
// [RQ16] length registers clear on reset and after successful reception
// [RQ17] command 87 decodes as conversion trigger
// [RQ18] command 84 selects main word, 85 selects aux word
// [RQ19] synth words move as three bytes msb first, applied after third
module rrp_regs (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_nrst,
    input  wire logic                   i_en,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire logic [5:0]             i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_cmd_valid,
    input  wire logic [7:0]             i_cmd,
    input  wire logic                   i_rx_success,
    input  wire logic [7:0]             i_adc_sample,
    output logic      [7:0]             o_rdata,
    output logic                        o_rdata_valid,
    output rrp_pkg::rrp_synth_type      o_synth,
    output logic                        o_use_aux,
    output logic                        o_ext_rf,
    output logic                        o_presc_en,
    output logic                        o_vco_level,
    output logic      [7:0]             o_dac,
    output logic                        o_adc_start,
    output logic                        o_adc_busy,
    output rrp_pkg::rrp_rx_cfg_type     o_rx_cfg
);
    import rrp_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] en_sync_q;
    logic [7:0] adc_s1_q;
    logic [7:0] adc_s2_q;

    // enable pin and analog sample pass two flops
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            en_sync_q <= 2'b00;
            adc_s1_q  <= 8'h00;
            adc_s2_q  <= 8'h00;
        end else begin
            en_sync_q <= {en_sync_q[0], i_en};
            adc_s1_q  <= i_adc_sample;
            adc_s2_q  <= adc_s1_q;
        end
    end

    logic en_ok;
    logic cmd_init;
    logic clr_all;
    assign en_ok    = en_sync_q[1];
    assign cmd_init = i_cmd_valid && (i_cmd == CMD_SOFT_INIT);
    // enable low or soft init preset the synth words, hop select, dac level, lengths and byte pointers; not the conversion sequencer, result or read data
    assign clr_all  = !en_ok || cmd_init;

    // ----------------------------------------------------------------
    // three-byte staging
    // ----------------------------------------------------------------
    logic [1:0]  wr_idx_q;
    logic [1:0]  rd_idx_q;
    logic [15:0] stage_q;
    logic [5:0]  last_addr_q;
    logic        wide_sel;
    assign wide_sel = (i_addr == ADDR_SYNTH_MAIN) || (i_addr == ADDR_SYNTH_AUX);

    // [RQ19] byte pointer per access
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_idx_q    <= 2'd0;
            rd_idx_q    <= 2'd0;
            stage_q     <= 16'h0000;
            last_addr_q <= 6'h00;
        end else if (clr_all) begin
            wr_idx_q <= 2'd0;
            rd_idx_q <= 2'd0;
        end else if ((i_wr || i_rd) && wide_sel) begin
            last_addr_q <= i_addr;
            if (i_wr) begin
                rd_idx_q <= 2'd0;
                if (i_addr != last_addr_q || wr_idx_q == 2'd0) begin
                    stage_q  <= {i_wdata, 8'h00};
                    wr_idx_q <= 2'd1;
                end else if (wr_idx_q == 2'd1) begin
                    stage_q[7:0] <= i_wdata;
                    wr_idx_q     <= 2'd2;
                end else begin
                    wr_idx_q <= 2'd0;
                end
            end else begin
                wr_idx_q <= 2'd0;
                if (i_addr != last_addr_q || rd_idx_q == 2'd2) begin
                    rd_idx_q <= (i_addr != last_addr_q) ? 2'd1 : 2'd0;
                end else begin
                    rd_idx_q <= rd_idx_q + 2'd1;
                end
            end
        end else if (i_wr || i_rd) begin
            wr_idx_q <= 2'd0;
            rd_idx_q <= 2'd0;
        end
    end

    logic word_commit;
    assign word_commit = i_wr && wide_sel && !clr_all
                         && (i_addr == last_addr_q) && (wr_idx_q == 2'd2);

    // ----------------------------------------------------------------
    // synthesizer words
    // ----------------------------------------------------------------
    logic [23:0] main_q;
    logic [23:0] aux_q;
    logic        use_aux_q;

    // [RQ3] [RQ4] presets, committed after third byte
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            main_q <= RST_SYNTH_MAIN;
            aux_q  <= RST_SYNTH_AUX;
        end else if (clr_all) begin
            main_q <= RST_SYNTH_MAIN;
            aux_q  <= RST_SYNTH_AUX;
        end else if (word_commit && i_addr == ADDR_SYNTH_MAIN) begin
            main_q <= {stage_q, i_wdata};
        end else if (word_commit && i_addr == ADDR_SYNTH_AUX) begin
            aux_q <= {stage_q, i_wdata};
        end
    end

    // [RQ18] frequency hop commands
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            use_aux_q <= 1'b0;
        end else if (clr_all || (i_cmd_valid && i_cmd == CMD_HOP_MAIN)) begin
            use_aux_q <= 1'b0;
        end else if (i_cmd_valid && i_cmd == CMD_HOP_AUX) begin
            use_aux_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // synthesizer outputs
    // ----------------------------------------------------------------
    rrp_synth_type synth_q;
    logic          ext_rf_q;
    logic          presc_q;
    logic          vco_q;
    logic [23:0]   act_word;
    assign act_word = use_aux_q ? aux_q : main_q;

    // [RQ1] [RQ2] [RQ5] [RQ6] field split of active word; aux flag bits always taken from aux word
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            synth_q  <= '0;
            ext_rf_q <= 1'b0;
            presc_q  <= 1'b0;
            vco_q    <= 1'b0;
        end else begin
            synth_q.bias_boost <= act_word[BIT_BIAS_BOOST];
            // aux word has no divider field; reference stays from main
            synth_q.reference_divider_select <= main_q[REF_SEL_HI:REF_SEL_LO];
            synth_q.b_count  <= act_word[B_HI:B_LO];
            synth_q.a_count  <= act_word[A_HI:A_LO];
            ext_rf_q <= aux_q[BIT_EXT_RF];
            presc_q  <= aux_q[BIT_PRESC_EN];
            vco_q    <= aux_q[BIT_VCO_LEVEL];
        end
    end

    // ----------------------------------------------------------------
    // dac level
    // ----------------------------------------------------------------
    logic [7:0] dac_q;

    // [RQ7] writable level, cleared on reset
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            dac_q <= RST_DAC;
        end else if (clr_all) begin
            dac_q <= RST_DAC;
        end else if (i_wr && i_addr == ADDR_DAC) begin
            dac_q <= i_wdata;
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    rrp_adc_state_type adc_st_q;
    logic [15:0]       adc_cnt_q;
    logic [7:0]        adc_res_q;
    logic              adc_start_q;
    logic              trig;
    // [RQ17] conversion trigger decode
    assign trig = i_cmd_valid && (i_cmd == CMD_ADC_TRIG) && en_ok;

    // [RQ8] result latched 20 us after trigger
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            adc_st_q    <= ADC_IDLE;
            adc_cnt_q   <= 16'h0000;
            adc_res_q   <= 8'h00;
            adc_start_q <= 1'b0;
        end else begin
            adc_start_q <= trig;
            if (trig) begin
                adc_st_q  <= ADC_BUSY;
                adc_cnt_q <= 16'(ADC_CYCLES - 1);
            end else begin
                unique case (adc_st_q)
                    ADC_IDLE: begin
                        adc_cnt_q <= 16'h0000;
                    end
                    ADC_BUSY: begin
                        if (adc_cnt_q == 16'h0000) begin
                            adc_res_q <= adc_s2_q;
                            adc_st_q  <= ADC_DONE;
                        end else begin
                            adc_cnt_q <= adc_cnt_q - 16'h0001;
                        end
                    end
                    ADC_DONE: begin
                        adc_st_q <= ADC_IDLE;
                    end
                    default: begin
                        adc_st_q <= ADC_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // receive length
    // ----------------------------------------------------------------
    logic [7:0] rxl_hi_q;
    logic [7:0] rxl_lo_q;
    logic [1:0] force_q;

    // [RQ16] clear on reset and at reception success
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rxl_hi_q <= RST_RXLEN;
            rxl_lo_q <= RST_RXLEN;
        end else if (clr_all || i_rx_success) begin
            rxl_hi_q <= RST_RXLEN;
            rxl_lo_q <= RST_RXLEN;
        end else if (i_wr && i_addr == ADDR_RXLEN_HI) begin
            // reserved bits 5:2 stay zero
            rxl_hi_q <= {i_wdata[7:6], 4'h0, i_wdata[1:0]};
        end else if (i_wr && i_addr == ADDR_RXLEN_LO) begin
            rxl_lo_q <= i_wdata;
        end
    end

    // [RQ14] [RQ15] command length override until reception ends
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            force_q <= 2'b00;
        end else if (clr_all || i_rx_success) begin
            force_q <= 2'b00;
        end else if (i_cmd_valid && i_cmd >= CMD_INV_FIRST && i_cmd <= CMD_INV_LAST) begin
            force_q <= 2'b01;
        end else if (i_cmd_valid && i_cmd == CMD_REQ_RN) begin
            force_q <= 2'b10;
        end
    end

    rrp_rx_cfg_type rx_cfg_q;
    logic [9:0]     len_eff;
    // [RQ12] ten-bit length assembly
    assign len_eff = force_q[0] ? RXLEN_TAG_RANDOM_16 :
                     force_q[1] ? RXLEN_TAG_RANDOM_16_CRC : {rxl_hi_q[1:0], rxl_lo_q};

    // [RQ10] [RQ11] [RQ13] receive options to receiver
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_cfg_q <= '0;
        end else begin
            rx_cfg_q.single_rx_skip_check <= rxl_hi_q[BIT_SKIP_CHECK];
            rx_cfg_q.raw_fifo_irq_remap   <= rxl_hi_q[BIT_IRQ_REMAP];
            rx_cfg_q.bit_count            <= len_eff;
            rx_cfg_q.stop_on_pause        <= (len_eff == 10'd0);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic [1:0] rd_byte;
    logic [23:0] rd_word;
    assign rd_byte = (i_addr != last_addr_q) ? 2'd0 : rd_idx_q;
    assign rd_word = (i_addr == ADDR_SYNTH_MAIN) ? main_q : aux_q;

    // [RQ19] registered read data, msb byte first
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_rd;
            if (i_rd) begin
                unique case (i_addr)
                    ADDR_SYNTH_MAIN, ADDR_SYNTH_AUX: begin
                        rdata_q <= (rd_byte == 2'd0) ? rd_word[23:16] :
                                   (rd_byte == 2'd1) ? rd_word[15:8] : rd_word[7:0];
                    end
                    ADDR_DAC:      rdata_q <= dac_q;
                    ADDR_ADC:      rdata_q <= adc_res_q;
                    ADDR_RXLEN_HI: rdata_q <= rxl_hi_q;
                    ADDR_RXLEN_LO: rdata_q <= rxl_lo_q;
                    default:       rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_rdata       = rdata_q;
    assign o_rdata_valid = rvalid_q;
    assign o_synth       = synth_q;
    assign o_use_aux     = use_aux_q;
    assign o_ext_rf      = ext_rf_q;
    assign o_presc_en    = presc_q;
    assign o_vco_level   = vco_q;
    assign o_dac         = dac_q;
    assign o_adc_start   = adc_start_q;
    assign o_adc_busy    = adc_st_q[1];
    assign o_rx_cfg      = rx_cfg_q;

endmodule // rrp_regs

/* rrp_regs_props.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// checker for the register block ports
// ------------------------------------------------------------
module rrp_regs_props (
    input wire logic                    i_clk_sys,
    input wire logic                    i_nrst,
    input wire logic                    i_rd,
    input wire logic                    i_cmd_valid,
    input wire logic [7:0]              i_cmd,
    input wire logic                    i_rx_success,
    input wire logic [7:0]              o_rdata,
    input wire logic                    o_rdata_valid,
    input wire logic                    o_use_aux,
    input wire logic                    o_adc_start,
    input wire logic                    o_adc_busy,
    input wire rrp_pkg::rrp_rx_cfg_type o_rx_cfg
);
    import rrp_pkg::*;

    logic [12:0] busy_cnt_q;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    // length of the current busy stretch
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_cnt_q <= 13'h0;
        end else begin
            busy_cnt_q <= o_adc_busy ? busy_cnt_q + 13'h1 : 13'h0;
        end
    end

    busy_len_a: assert property ($fell(o_adc_busy) |-> busy_cnt_q == 13'(ADC_CYCLES))
        else $error("conversion busy length wrong");
    adc_trigger_a: assert property (i_cmd_valid && i_cmd == CMD_ADC_TRIG |=> o_adc_start)
        else $error("conversion start missing");
    adc_cause_a: assert property (o_adc_start |-> $past(i_cmd_valid) &&
        $past(i_cmd) == CMD_ADC_TRIG ##1 !o_adc_start) else $error("stray conversion start");
    hop_aux_a: assert property (i_cmd_valid && i_cmd == CMD_HOP_AUX |-> ##[1:2] o_use_aux)
        else $error("aux word not selected");
    hop_main_a: assert property (i_cmd_valid && i_cmd == CMD_HOP_MAIN |-> ##[1:2] !o_use_aux)
        else $error("main word not selected");
    force_inv_a: assert property (i_cmd_valid && i_cmd inside {[CMD_INV_FIRST:CMD_INV_LAST]}
        |-> ##[1:3] o_rx_cfg.bit_count == RXLEN_TAG_RANDOM_16) else $error("inventory length not 16");
    force_rn_a: assert property (i_cmd_valid && i_cmd == CMD_REQ_RN
        |-> ##[1:3] o_rx_cfg.bit_count == RXLEN_TAG_RANDOM_16_CRC) else $error("length not 32");
    rx_clear_a: assert property (i_rx_success |-> ##[1:3] o_rx_cfg.bit_count == 10'h0 &&
        !o_rx_cfg.single_rx_skip_check && !o_rx_cfg.raw_fifo_irq_remap)
        else $error("length not cleared");
    pause_mode_a: assert property (o_rx_cfg.bit_count != 10'h0 |-> !o_rx_cfg.stop_on_pause)
        else $error("pause stop with nonzero length");
    read_valid_a: assert property (o_rdata_valid |-> $past(i_rd))
        else $error("read data without request");
    read_hold_a: assert property (!o_rdata_valid |-> $stable(o_rdata))
        else $error("read data moved without read");

    // main scenarios reached
    cover property (o_adc_start);
    cover property (i_rx_success);
    cover property ($rose(o_use_aux));
endmodule // rrp_regs_props

bind rrp_regs rrp_regs_props u_props (
    .i_clk_sys, .i_nrst, .i_rd, .i_cmd_valid, .i_cmd, .i_rx_success, .o_rdata,
    .o_rdata_valid, .o_use_aux, .o_adc_start, .o_adc_busy, .o_rx_cfg
);

/* rrp_analog_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// converter and receiver stand-in
// ------------------------------------------------------------
module rrp_analog_model #(
    parameter int SETTLE = 3000
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_adc_start,
    input  wire logic [7:0] i_level,
    input  wire logic       i_rx_req,
    output logic      [7:0] o_adc_sample = 8'h0,
    output logic            o_rx_success = 1'b0
);
    int cnt_q = 0;

    always @(posedge i_clk_sys) begin
        cnt_q <= i_adc_start ? SETTLE : (cnt_q != 0 ? cnt_q - 1 : 0);
        o_adc_sample <= (cnt_q != 0) ? ~o_adc_sample : i_level; // garbage while settling
        o_rx_success <= i_rx_req; // one pulse per end of frame
    end
endmodule // rrp_analog_model

/* tb_top.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// register block testbench
// ------------------------------------------------------------
module tb_top;
    import rrp_pkg::*;

    logic           i_clk_sys = 1'b0;
    logic           i_nrst = 1'b0;
    logic           i_en = 1'b1;
    logic           i_wr = 1'b0;
    logic           i_rd = 1'b0;
    logic [5:0]     i_addr = 6'h0;
    logic [7:0]     i_wdata = 8'h0;
    logic           i_cmd_valid = 1'b0;
    logic [7:0]     i_cmd = 8'h0;
    logic           i_rx_success, rx_req = 1'b0;
    logic [7:0]     i_adc_sample, o_rdata, o_dac, level = 8'h0;
    logic           o_rdata_valid, o_use_aux, o_ext_rf, o_presc_en, o_vco_level;
    logic           o_adc_start, o_adc_busy;
    rrp_synth_type  o_synth;
    rrp_rx_cfg_type o_rx_cfg;
    logic [7:0]     rq[$];
    logic [2:0]     refs[6] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b110, 3'b111};
    logic [23:0]    v, m, x;
    int             fails = 0, num_checks = 0, seed = 32'h9a6808a4, k;

    rrp_regs dut (
        .i_clk_sys, .i_nrst, .i_en, .i_wr, .i_rd, .i_addr, .i_wdata, .i_cmd_valid, .i_cmd,
        .i_rx_success, .i_adc_sample, .o_rdata, .o_rdata_valid, .o_synth, .o_use_aux,
        .o_ext_rf, .o_presc_en, .o_vco_level, .o_dac, .o_adc_start, .o_adc_busy, .o_rx_cfg
    );
    rrp_analog_model #(.SETTLE(3900)) u_model (
        .i_clk_sys, .i_adc_start(o_adc_start), .i_level(level), .i_rx_req(rx_req),
        .o_adc_sample(i_adc_sample), .o_rx_success(i_rx_success)
    );

    // 200 MHz clock
    always #2.5 i_clk_sys = ~i_clk_sys;

    // collect read bytes
    always @(posedge i_clk_sys) if (o_rdata_valid === 1'b1) rq.push_back(o_rdata);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(logic [5:0] a, logic [23:0] d, int n);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        for (int i = n - 1; i >= 0; i--) begin
            i_wdata <= d[8*i +: 8];
            @(posedge i_clk_sys);
        end
        i_wr <= 1'b0;
    endtask

    task automatic rd(logic [5:0] a, int n, output logic [23:0] r);
        rq = {};
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        repeat (n) @(posedge i_clk_sys);
        i_rd <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        r = 24'h0;
        foreach (rq[i]) r = {r[15:0], rq[i]};
    endtask

    task automatic cmd(logic [7:0] c);
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
    endtask

    function automatic rrp_synth_type syn_exp(logic [23:0] mw, logic [23:0] aw, logic ua);
        syn_exp = ua ? aw : mw;
        syn_exp.reference_divider_select = mw[22:20];
    endfunction

    function automatic logic [23:0] rx_exp(logic [7:0] hi, logic [7:0] lo);
        rx_exp = 24'({hi[7], hi[6], hi[1:0], lo, {hi[1:0], lo} == 10'h0});
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: run needs about 4400 cycles, allow 80000 (about eighteen times that)
    initial begin
        #400000;
        fails++;
        final_report;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        rd(ADDR_SYNTH_MAIN, 3, v);
        chk("main preset", RST_SYNTH_MAIN, v);
        rd(ADDR_SYNTH_AUX, 3, v);
        chk("aux preset", RST_SYNTH_AUX, v);
        chk("synth out preset", RST_SYNTH_MAIN, o_synth);
        for (k = 0; k < 3; k++) begin
            rd(6'(ADDR_DAC + k * 2), 1, v);
            chk("byte preset", 24'h0, v);
        end
        rd(ADDR_RXLEN_LO, 1, v);
        chk("len lo preset", 24'h0, v);
        $display("test reset values done");
        foreach (refs[i]) begin
            m = 24'($random(seed));
            m[22:20] = refs[i];
            x = 24'($random(seed));
            wr(ADDR_SYNTH_MAIN, m, 3);
            wr(ADDR_SYNTH_AUX, x, 3);
            repeat (2) @(posedge i_clk_sys);
            chk("synth main", syn_exp(m, x, 1'b0), o_synth);
            rd(ADDR_SYNTH_AUX, 3, v);
            chk("aux readback", x, v);
            cmd(CMD_HOP_AUX);
            chk("synth aux", syn_exp(m, x, 1'b1), o_synth);
            chk("aux flags", 24'(x[22:20]), 24'({o_vco_level, o_ext_rf, o_presc_en}));
            cmd(CMD_HOP_MAIN);
            chk("hop main", 24'h0, 24'(o_use_aux));
        end
        level <= 8'($random(seed)); // input chosen before trigger
        wr(ADDR_SYNTH_MAIN, 24'h00a55a, 2);
        wr(ADDR_DAC, 24'(level), 1);
        rd(ADDR_SYNTH_MAIN, 3, v);
        chk("partial word kept", m, v);
        chk("dac out", 24'(level), 24'(o_dac));
        wr(6'h3f, 24'hff, 1);
        rd(6'h3f, 1, v);
        chk("unmapped read", 24'h0, v);
        $display("test synth and dac done");
        cmd(CMD_ADC_TRIG);
        for (k = 0; k < 5000 && o_adc_busy !== 1'b0; k++) @(posedge i_clk_sys);
        chk("conversion ended", 24'h0, 24'(o_adc_busy));
        wr(ADDR_ADC, 24'(~level), 1);
        rd(ADDR_ADC, 1, v);
        chk("conversion result", 24'(level), v);
        $display("test conversion done");
        for (k = 0; k < 6; k++) begin
            m = 24'($random(seed));
            if (k == 0) m[15:0] = 16'h00c0;
            wr(ADDR_RXLEN_HI, m, 1);
            wr(ADDR_RXLEN_LO, m >> 8, 1);
            repeat (2) @(posedge i_clk_sys);
            chk("rx cfg", rx_exp(m[7:0], m[15:8]), o_rx_cfg);
            rd(ADDR_RXLEN_HI, 1, v);
            chk("len hi readback", 24'(m[7:0] & 8'hc3), v);
            cmd(k == 5 ? CMD_REQ_RN : CMD_INV_FIRST + 8'(k));
            chk("forced len", k == 5 ? 24'd32 : 24'd16, 24'(o_rx_cfg.bit_count));
            @(posedge i_clk_sys);
            rx_req <= 1'b1;
            @(posedge i_clk_sys);
            rx_req <= 1'b0;
            repeat (4) @(posedge i_clk_sys);
            chk("rx cleared", rx_exp(8'h0, 8'h0), o_rx_cfg);
            rd(ADDR_RXLEN_LO, 1, v);
            chk("len lo cleared", 24'h0, v);
        end
        $display("test receive length done");
        wr(ADDR_DAC, 24'h5a, 1);
        i_en <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_en <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        rd(ADDR_DAC, 1, v);
        chk("dac after enable low", 24'h0, v);
        rd(ADDR_SYNTH_MAIN, 3, v);
        chk("main after enable low", RST_SYNTH_MAIN, v);
        wr(ADDR_DAC, 24'h3c, 1);
        cmd(CMD_SOFT_INIT);
        rd(ADDR_DAC, 1, v);
        chk("dac after soft init", 24'h0, v);
        $display("test enable preset done");
        final_report;
    end
endmodule // tb_top
